// ---- src/bl_ctrl.sv ----
// Backlight fault detection, mode and brightness control top.
`timescale 1ns/100ps
`default_nettype none
`include "bl_ctrl_regs.svh"
module bl_ctrl #(
   parameter int STRINGS = 6,
   parameter int BOOST_BITS = 4
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic chip_enable_pin_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   input wire logic pwm_in,
   input wire logic [STRINGS-1:0] cmp_low_in,
   input wire logic [STRINGS-1:0] cmp_mid_in,
   input wire logic [STRINGS-1:0] cmp_high_in,
   input wire logic vin_below_2v5_in,
   input wire logic vin_below_5v2_in,
   input wire logic overcurrent_in,
   input wire logic hot_150_in,
   input wire logic cool_130_in,
   input wire logic ovp_in,
   input wire logic vref_ok_in,
   input wire logic vboost_ok_in,
   output logic [BOOST_BITS-1:0] boost_req_out,
   output logic boost_en_out,
   output logic led_en_out,
   output logic led_pwm_out,
   output bl_ctrl_pkg::mode_e mode_out
);
   import bl_ctrl_pkg::*;
   slope_if s ();
   logic en_q;
   mode_e mode_q;
   byte_t bright_q, devctl_q, config_q, status_q;
   logic uv_q, tsd_q;
   logic [BOOST_BITS-1:0] boost_q;
   logic [15:0] bcnt_q;
   logic [7:0] pcnt_q, hi_cnt_q, duty_q;
   logic pwm_d1_q;
   logic [8:0] width_q;
   logic [STRINGS-1:0] optimized;
   logic open_ev, short_ev, uv_now, on_req, rd_status;
   byte_t status_d, rdata_d;
   bl_slope #(.SLOPE_MAX_CYCLES(10000000)) u_slope (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .s(s)
   );
   assign rd_status = reg_rd_in && reg_addr_in == `STATUS_ADDR;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         en_q <= 1'b0;
      end else begin
         en_q <= chip_enable_pin_in;
      end
   end
   // Source 00 turns on from PWM activity, others from on-bit. [RULE17]
   assign on_req = (devctl_q[`DC_SRC_LSB +: 2] == 2'b00) ? (duty_q != 8'h00)
      : devctl_q[`DC_ON];
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_q <= MODE_SHUTDOWN;
      end else if (!en_q) begin
         mode_q <= MODE_SHUTDOWN; // [RULE16]
      end else begin
         unique case (mode_q)
            MODE_SHUTDOWN: mode_q <= MODE_STANDBY;
            MODE_STANDBY: if (on_req) mode_q <= MODE_ACTIVE;
            MODE_ACTIVE: if (!on_req) mode_q <= MODE_STANDBY;
         endcase
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bright_q <= 8'h00;
         devctl_q <= `DEVCTL_RESET;
         config_q <= `CONFIG_RESET;
      end else if (!en_q) begin
         devctl_q <= `DEVCTL_RESET;
      end else if (reg_wr_in) begin
         if (reg_addr_in == `BRIGHT_ADDR) bright_q <= reg_wdata_in;
         if (reg_addr_in == `DEVCTL_ADDR) devctl_q <= reg_wdata_in;
         if (reg_addr_in == `CONFIG_ADDR && mode_q != MODE_ACTIVE) begin
            config_q <= reg_wdata_in; // [RULE19]
         end
      end
   end
   // PWM duty measured over 256-cycle windows. [RULE18]
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pcnt_q <= 8'h00;
         hi_cnt_q <= 8'h00;
         duty_q <= 8'h00;
      end else begin
         pcnt_q <= pcnt_q + 8'h01;
         if (pcnt_q == 8'hFF) begin
            duty_q <= hi_cnt_q + {7'h00, pwm_in};
            hi_cnt_q <= 8'h00;
         end else if (pwm_in) begin
            hi_cnt_q <= hi_cnt_q + 8'h01;
         end
      end
   end
   assign s.target = (devctl_q[`DC_SRC_LSB +: 2] == 2'b00) ? duty_q
      : bright_q; // [RULE18]
   assign s.slope_sel = config_q[`CF_SLOPE_LSB +: 3]; // [RULE1]
   assign s.dither_depth = config_q[`CF_DITH_LSB +: 2]; // [RULE3]
   assign s.hold_dither_en = config_q[`CF_HOLD]; // [RULE4]
   assign s.pwm_tick = (pcnt_q == 8'hFF);
   // Selected threshold; disabled detector never trips. [RULE11]
   assign uv_now = config_q[`CF_UV_EN] &&
      (config_q[`CF_UV_SEL] ? vin_below_5v2_in : vin_below_2v5_in);
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         uv_q <= 1'b0;
         tsd_q <= 1'b0;
      end else begin
         uv_q <= uv_now; // [RULE12]
         if (hot_150_in) tsd_q <= 1'b1; // [RULE15]
         else if (cool_130_in) tsd_q <= 1'b0;
      end
   end
   // Low comparator steps boost request up; down only with no low, some high and some string with mid set. [RULE8]
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         boost_q <= '0;
         bcnt_q <= 16'h0000;
      end else if (mode_q != MODE_ACTIVE) begin
         boost_q <= '0;
         bcnt_q <= 16'h0000;
      end else if (bcnt_q == `BOOST_STEP_CYCLES) begin
         bcnt_q <= 16'h0000;
         if (|cmp_low_in && boost_q != '1) boost_q <= boost_q + BOOST_BITS'(1);
         else if (&(optimized | cmp_low_in) == 1'b0 && boost_q != '0 &&
            |cmp_high_in && !(|cmp_low_in)) boost_q <= boost_q - BOOST_BITS'(1);
      end else begin
         bcnt_q <= bcnt_q + 16'h0001;
      end
   end
   assign optimized = ~cmp_mid_in & ~cmp_low_in; // [RULE9]
   assign open_ev = mode_q == MODE_ACTIVE && boost_q == '1 &&
      |cmp_low_in; // [RULE7]
   always_comb begin
      short_ev = 1'b0;
      for (int i = 0; i < STRINGS; i++) begin
         for (int j = 0; j < STRINGS; j++) begin
            if (i != j && optimized[i] && !cmp_high_in[i] && cmp_high_in[j])
               short_ev = 1'b1; // [RULE10]
         end
      end
      short_ev = short_ev && mode_q == MODE_ACTIVE;
   end
   // Flags latch; new event wins over read clear. [RULE21] [RULE20]
   always_comb begin
      status_d = rd_status ? `STATUS_RESET : status_q; // [RULE6]
      if (!en_q) status_d[`ST_UV] = 1'b0; // [RULE13]
      if (open_ev) status_d[`ST_OPEN] = 1'b1;
      if (short_ev) status_d[`ST_SHORT] = 1'b1;
      if (vref_ok_in) status_d[`ST_VREF] = 1'b1;
      if (vboost_ok_in) status_d[`ST_VBOOST] = 1'b1;
      if (ovp_in) status_d[`ST_OVP] = 1'b1;
      if (overcurrent_in) status_d[`ST_OCP] = 1'b1; // [RULE14]
      if (hot_150_in) status_d[`ST_TSD] = 1'b1; // [RULE15]
      if (uv_now && en_q) status_d[`ST_UV] = 1'b1; // [RULE12]
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         status_q <= `STATUS_RESET;
      end else begin
         status_q <= status_d;
      end
   end
   always_comb begin
      unique case (reg_addr_in)
         `BRIGHT_ADDR: rdata_d = bright_q;
         `DEVCTL_ADDR: rdata_d = devctl_q;
         `STATUS_ADDR: rdata_d = status_q;
         `CONFIG_ADDR: rdata_d = config_q;
         default: rdata_d = 8'h00;
      endcase
   end
   // PWM out: 256-cycle period, duty level plus one when stretched. [RULE5]
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= 8'h00;
         boost_req_out <= '0;
         boost_en_out <= 1'b0;
         led_en_out <= 1'b0;
         led_pwm_out <= 1'b0;
         mode_out <= MODE_SHUTDOWN;
         width_q <= 9'h000;
      end else begin
         if (reg_rd_in) reg_rdata_out <= rdata_d;
         boost_req_out <= boost_q;
         // Boost stops on any of the three faults. [RULE12] [RULE14] [RULE15]
         boost_en_out <= mode_q == MODE_ACTIVE && !uv_q && !tsd_q &&
            !overcurrent_in;
         led_en_out <= mode_q == MODE_ACTIVE && !uv_q && !tsd_q;
         if (s.pwm_tick) width_q <= {1'b0, s.level} + {8'h00, s.stretch};
         led_pwm_out <= {1'b0, pcnt_q} < width_q && mode_q == MODE_ACTIVE;
         mode_out <= mode_q;
      end
   end
endmodule : bl_ctrl
`default_nettype wire

// ---- src/bl_ctrl_regs.svh ----
// Register offsets, field positions, reset values and timing counts.
// Notes on behaviour
// RULE1: Ramp brightness over 3-bit programmed slope time.
// RULE2: Same slope time for up and down.
// RULE3: Dither depth zero to three extra bits.
// RULE4: Hold bit keeps dithering in steady state; the code has no effect there, as the fraction is zero when not ramping.
// RULE5: Three-bit dither lengthens one pulse per eight.
// RULE6: Status read clears latched fault flags.
// RULE7: Open flag: max boost request with low comparator.
// RULE8: Low comparator raises requested boost level.
// RULE9: String optimized when mid and low deasserted.
// RULE10: Short: optimized string plus another string high.
// RULE11: Undervoltage enable and threshold select.
// RULE12: Undervoltage stops outputs, flags, restarts automatically.
// RULE13: Undervolt flag clears on enable low or read.
// RULE14: Overcurrent stops boost, flags, restarts when cleared.
// RULE15: Thermal stops outputs and boost, flags, hysteresis.
// RULE16: Shutdown while chip enable pin is low.
// RULE17: Source code 00 uses PWM input, else on-bit.
// RULE18: Brightness from register or measured PWM duty.
// RULE19: Configuration writes blocked in active mode.
// RULE20: Status layout bit7 open to bit0 undervolt.
// RULE21: Flags stay set until an explicit clear.
`ifndef BL_CTRL_REGS_SVH
`define BL_CTRL_REGS_SVH
`define BRIGHT_ADDR 8'h00
`define DEVCTL_ADDR 8'h01
`define STATUS_ADDR 8'h02
`define CONFIG_ADDR 8'h03
`define STATUS_RESET 8'h00
`define DEVCTL_RESET 8'h00
`define CONFIG_RESET 8'h00
`define ST_OPEN 7
`define ST_SHORT 6
`define ST_VREF 5
`define ST_VBOOST 4
`define ST_OVP 3
`define ST_OCP 2
`define ST_TSD 1
`define ST_UV 0
`define DC_ON 0
`define DC_SRC_LSB 1
`define CF_SLOPE_LSB 0
`define CF_DITH_LSB 3
`define CF_HOLD 5
`define CF_UV_EN 6
`define CF_UV_SEL 7
`define SLOPE_MAX_MS 500
`define CLK_HZ 20000000
`define BOOST_STEP_CYCLES 16'd1000
`endif

// ---- src/bl_ctrl_pkg.sv ----
// Types shared by the backlight controller modules.
package bl_ctrl_pkg;
   typedef enum logic [2:0] {
      MODE_SHUTDOWN = 3'b001,
      MODE_STANDBY = 3'b010,
      MODE_ACTIVE = 3'b100
   } mode_e;
   typedef logic [7:0] byte_t;
endpackage : bl_ctrl_pkg

// ---- src/slope_if.sv ----
// Interface carrying ramp settings to the slope engine and its results back.
`timescale 1ns/100ps
`default_nettype none
interface slope_if;
   logic [7:0] target;
   logic [2:0] slope_sel;
   logic [1:0] dither_depth;
   logic hold_dither_en;
   logic pwm_tick;
   logic [7:0] level;
   logic stretch;
   logic ramping;
   modport ctrl (output target, slope_sel, dither_depth, hold_dither_en,
      pwm_tick, input level, stretch, ramping);
   modport eng (input target, slope_sel, dither_depth, hold_dither_en,
      pwm_tick, output level, stretch, ramping);
endinterface : slope_if
`default_nettype wire

// ---- src/bl_slope.sv ----
// Brightness slope engine with fractional dithering.
`timescale 1ns/100ps
`default_nettype none
`include "bl_ctrl_regs.svh"
module bl_slope #(
   parameter int SLOPE_MAX_CYCLES = `SLOPE_MAX_MS * (`CLK_HZ / 1000)
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   slope_if.eng s
);
   // Full scale is 256 levels of 8 substeps each, 2048 steps in all.
   localparam int STEP_MAX = SLOPE_MAX_CYCLES / 2048;
   logic [10:0] cur_q;
   logic [23:0] cnt_q;
   logic [2:0] phase_q;
   logic [23:0] step_cycles;
   logic [2:0] frac;
   always_comb begin
      step_cycles = 24'(STEP_MAX * s.slope_sel / 7);
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cur_q <= 11'h000;
         cnt_q <= 24'h00_0000;
      end else if (cur_q[10:3] == s.target && cur_q[2:0] == 3'h0) begin
         cnt_q <= 24'h00_0000;
      end else if (cnt_q >= step_cycles) begin
         cnt_q <= 24'h00_0000;
         // Same step period in both directions. [RULE1] [RULE2]
         if (cur_q[10:3] < s.target) begin
            cur_q <= cur_q + 11'h001;
         end else begin
            cur_q <= cur_q - 11'h001;
         end
      end else begin
         cnt_q <= cnt_q + 24'h00_0001;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase_q <= 3'h0;
      end else if (s.pwm_tick) begin
         phase_q <= phase_q + 3'h1;
      end
   end
   always_comb begin
      // Fraction kept to the programmed depth. [RULE3]
      unique case (s.dither_depth)
         2'd0: frac = 3'h0;
         2'd1: frac = {cur_q[2], 2'b00};
         2'd2: frac = {cur_q[2:1], 1'b0};
         default: frac = cur_q[2:0];
      endcase
   end
   assign s.ramping = !(cur_q[10:3] == s.target && cur_q[2:0] == 3'h0);
   assign s.level = cur_q[10:3];
   // Pulse k of eight stretched by one step when bit-reversed k below fraction. [RULE5]
   assign s.stretch = (s.ramping || s.hold_dither_en) && // [RULE4]
      ({phase_q[0], phase_q[1], phase_q[2]} < frac);
endmodule : bl_slope
`default_nettype wire

// ---- testbench/pwm_src.sv ----
// PWM brightness source with a programmable duty over 256 cycles.
`timescale 1ns/100ps
`default_nettype none
module pwm_src (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] duty_in,
   output logic pwm_out
);
   logic [7:0] cnt_q;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q <= 8'h00;
         pwm_out <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 8'h01;
         pwm_out <= cnt_q < duty_in;
      end
   end
endmodule : pwm_src
`default_nettype wire

// ---- testbench/bl_ctrl_monitor.sv ----
// Checker of mode, fault and status behaviour at the controller ports.
`timescale 1ns/100ps
`default_nettype none
module bl_ctrl_monitor #(
   parameter int STRINGS = 6,
   parameter int BOOST_BITS = 4
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic chip_enable_pin_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic [STRINGS-1:0] cmp_low_in,
   input wire logic overcurrent_in,
   input wire logic hot_150_in,
   input wire logic [BOOST_BITS-1:0] boost_req_out,
   input wire logic boost_en_out,
   input wire logic led_en_out,
   input wire bl_ctrl_pkg::mode_e mode_out
);
   import bl_ctrl_pkg::*;
   logic rd_st;
   logic qt;
   assign rd_st = reg_rd_in && reg_addr_in == 8'h02;
   assign qt = !hot_150_in && !overcurrent_in;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   en_shut_a: assert property (
      (!chip_enable_pin_in)[*4] |-> mode_out == MODE_SHUTDOWN)
      else $error("mode not shutdown while disabled");
   en_off_a: assert property (
      (!chip_enable_pin_in)[*4] |-> !led_en_out && !boost_en_out)
      else $error("outputs on while disabled");
   hot_off_a: assert property (
      hot_150_in[*3] |-> !led_en_out && !boost_en_out)
      else $error("outputs on while hot");
   oc_off_a: assert property (
      overcurrent_in[*3] |-> !boost_en_out)
      else $error("boost on in overcurrent");
   hot_flag_a: assert property (
      (hot_150_in && chip_enable_pin_in)[*3] ##0 rd_st |=> reg_rdata_out[1])
      else $error("thermal flag missing");
   oc_flag_a: assert property (
      (overcurrent_in && chip_enable_pin_in)[*3] ##0 rd_st
      |=> reg_rdata_out[2])
      else $error("overcurrent flag missing");
   open_flag_a: assert property (
      (&boost_req_out && |cmp_low_in)[*3] ##0 rd_st |=> reg_rdata_out[7])
      else $error("open flag missing");
   read_clear_a: assert property (
      qt[*3] ##0 rd_st ##1 (qt && !rd_st) ##1 (qt && rd_st)
      |=> reg_rdata_out[2:1] == 2'b00)
      else $error("flags not cleared by read");
endmodule : bl_ctrl_monitor
bind bl_ctrl bl_ctrl_monitor #(.STRINGS(STRINGS), .BOOST_BITS(BOOST_BITS))
   i_mon (.clk_in, .rst_n_in, .chip_enable_pin_in, .reg_rd_in, .reg_addr_in,
   .reg_rdata_out, .cmp_low_in, .overcurrent_in, .hot_150_in, .boost_req_out,
   .boost_en_out, .led_en_out, .mode_out);
`default_nettype wire

// ---- testbench/tb.sv ----
// Register level testbench of the backlight controller.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import bl_ctrl_pkg::*;
   logic clk_in, rst_n, en, wr, rd, pwm, ben, len, lpwm;
   logic [7:0] addr, wdat, rdat, duty;
   logic [5:0] low, mid, high, f;
   logic [3:0] breq;
   mode_e mode;
   int mismatches, total_checks, cyc, hi;
   logic [7:0] e1 [6] = '{8'h02, 8'h04, 8'h01, 8'h00, 8'h20, 8'h10};
   logic [7:0] e2 [6] = '{8'h02, 8'h04, 8'h01, 8'h00, 8'h20, 8'h10};
   bl_ctrl i_dut (.clk_in(clk_in), .rst_n_in(rst_n),
      .chip_enable_pin_in(en), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_addr_in(addr), .reg_wdata_in(wdat), .reg_rdata_out(rdat),
      .pwm_in(pwm), .cmp_low_in(low), .cmp_mid_in(mid), .cmp_high_in(high),
      .vin_below_2v5_in(f[2]), .vin_below_5v2_in(f[2] | f[3]),
      .overcurrent_in(f[1]), .hot_150_in(f[0]), .cool_130_in(!f[0]),
      .ovp_in(1'b0), .vref_ok_in(f[4]), .vboost_ok_in(f[5]),
      .boost_req_out(breq), .boost_en_out(ben), .led_en_out(len),
      .led_pwm_out(lpwm), .mode_out(mode));
   pwm_src i_pwm (.clk_in(clk_in), .rst_n_in(rst_n), .duty_in(duty),
      .pwm_out(pwm));
   always #25 clk_in = ~clk_in;
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 60000) begin
         mismatches++;
         wrap_up();
      end
   end
   task automatic cmp8(input string n, input logic [7:0] e,
      input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : cmp8
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr <= a;
      wdat <= d;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1 cmp8("register", e, rdat);
   endtask : chk
   task automatic pulse(input int i);
      @(posedge clk_in);
      f <= 6'b1 << i;
      repeat (4) @(posedge clk_in);
      chk(8'h02, e1[i]);
      @(posedge clk_in);
      f <= 6'h00;
      repeat (3) @(posedge clk_in);
      chk(8'h02, e2[i]);
      chk(8'h02, 8'h00);
   endtask : pulse
   initial begin
      clk_in = 0;
      {rst_n, en, wr, rd, addr, wdat, duty, low, mid, high, f} = '0;
      repeat (12) @(posedge clk_in);
      rst_n <= 1'b1;
      en <= 1'b1;
      repeat (3) @(posedge clk_in);
      for (int a = 0; a < 5; a++) begin
         chk(a == 4 ? 8'h10 : 8'(a), 8'h00);
      end
      wr_reg(8'h03, 8'h40);
      chk(8'h03, 8'h40);
      wr_reg(8'h00, 8'h80);
      wr_reg(8'h01, 8'h03);
      for (int n = 0; n < 100 && mode !== MODE_ACTIVE; n++) @(posedge clk_in);
      cmp8("mode", 8'h04, {5'h00, mode});
      wr_reg(8'h03, 8'h87);
      chk(8'h03, 8'h40);
      for (int i = 0; i < 6; i++) pulse(i);
      low <= 6'h3F;
      for (int n = 0; n < 20000 && breq !== 4'hF; n++) @(posedge clk_in);
      cmp8("boost_req", 8'h0F, {4'h0, breq});
      hi = 0;
      repeat (256) begin
         @(posedge clk_in);
         #1 hi = hi + int'(lpwm);
      end
      cmp8("led_pwm", 8'h80, 8'(hi));
      chk(8'h02, 8'h80);
      low <= 6'h00;
      repeat (3) @(posedge clk_in);
      chk(8'h02, 8'h80);
      chk(8'h02, 8'h00);
      high <= 6'h01;
      repeat (3) @(posedge clk_in);
      chk(8'h02, 8'h40);
      mid <= 6'h3E;
      repeat (3) @(posedge clk_in);
      chk(8'h02, 8'h40);
      chk(8'h02, 8'h00);
      {high, mid, f} <= {6'h00, 6'h00, 6'h04};
      repeat (4) @(posedge clk_in);
      {f, en} <= 7'h00;
      repeat (4) @(posedge clk_in);
      en <= 1'b1;
      repeat (3) @(posedge clk_in);
      chk(8'h02, 8'h00);
      repeat (600) @(posedge clk_in);
      cmp8("led_en", 8'h00, {7'h00, len});
      duty <= 8'h40;
      for (int n = 0; n < 1000 && len !== 1'b1; n++) @(posedge clk_in);
      cmp8("led_en", 8'h01, {7'h00, len});
      wrap_up();
   end
endmodule : tb
`default_nettype wire
